/* core/sbsf_flag_cell.sv */
// one status flag with its read-then-access clearing sequence
`timescale 1ns/1ps
module sbsf_flag_cell (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic set_i,
   input wire logic status_read_i,
   input wire logic access_i,
   input wire logic flush_i,
   input wire logic reset_val_i,
   output logic flag_o,
   output logic armed_o
);
   logic flag_reg;
   logic flag_next;
   logic armed_reg;
   logic armed_next;
   logic clear_hit;

   // ----------------------------------------
   // clear sequence, set wins over clear
   // ----------------------------------------
   assign clear_hit = armed_reg & access_i;
   assign flag_next = set_i | (flag_reg & ~clear_hit & ~flush_i);
   assign armed_next = flag_next & ((status_read_i & flag_reg) | (armed_reg & ~access_i));
   assign flag_o = flag_reg;
   assign armed_o = armed_reg;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         flag_reg <= reset_val_i;
         armed_reg <= 1'b0;
      end else begin
         flag_reg <= flag_next;
         armed_reg <= armed_next;
      end
   end
endmodule

/* core/sbsf_pkg.sv */
// package: register map, field positions, reset values and sizes for the bit-rate/status block
// Notes on behaviour
// - prescale field bits 6:4 divides the bus clock by its value plus one.
// - prescaler runs from the bus clock and feeds the rate divider.
// - rate field bits 2:0 divides by two to the power field plus one.
// - master bit clock is bus clock over prescale divisor then rate divisor.
// - bit-rate register is readable and writable at any time, even mid-transfer.
// - status bits 6,3,2,1,0 read zero; status writes change nothing.
// - receive-full flag, status bit 7, sets when a transfer completes.
// - receive-full clears after status read with flag set, then data read.
// - transmit-empty, status bit 5, set on room; cleared by armed status read then data write.
// - data writes not preceded by a status read seeing transmit-empty are discarded.
// - transmit-empty with transmit interrupt enable requests an interrupt.
// - transmit-empty sets whenever a byte moves from buffer into shifter.
// - idle interface passes a written byte to the shifter within two cycles; code does this only with master 1, else the byte stays buffered.
// - at shift end a queued byte moves in and transmit-empty sets; else nothing.
// - mode-fault, status bit 4, sets when master sees select input driven low.
// - mode-fault sets only with master 1, fault enable 1, select output enable 0.
// - mode-fault clears after status read with flag set, then control-one write.
// - receive-full or mode-fault with receive/fault enable requests an interrupt.
// - clearing interface enable aborts transfers, clears receive-full, sets transmit-empty.
package sbsf_pkg;
   localparam int DATA_W = 32;
   localparam int ADR_W = 8;
   localparam int BYTE_W = 8;
   // register byte offsets
   localparam logic [7:0] OFS_BIT_RATE = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_DATA = 8'h08;
   localparam logic [7:0] OFS_CTRL_ONE = 8'h0C;
   localparam logic [7:0] OFS_CTRL_TWO = 8'h10;
   // bit-rate fields
   localparam int PRE_LSB = 4;
   localparam int RATE_LSB = 0;
   localparam int SEL_W = 3;
   localparam logic [7:0] BIT_RATE_MASK = 8'h77;
   localparam logic [7:0] BIT_RATE_RST = 8'h00;
   // status fields
   localparam int ST_RX_FULL = 7;
   localparam int ST_TX_EMPTY = 5;
   localparam int ST_FAULT = 4;
   // control one fields
   localparam int C1_RX_IRQ_EN = 7;
   localparam int C1_ENABLE = 6;
   localparam int C1_TX_IRQ_EN = 5;
   localparam int C1_MASTER = 4;
   localparam int C1_SEL_OUT_EN = 1;
   localparam logic [7:0] CTRL_ONE_MASK = 8'hF2;
   localparam logic [7:0] CTRL_ONE_RST = 8'h00;
   // control two fields
   localparam int C2_FAULT_EN = 4;
   localparam logic [7:0] CTRL_TWO_MASK = 8'h10;
   localparam logic [7:0] CTRL_TWO_RST = 8'h00;
   // serial frame: two clock edges per bit
   localparam int EDGES_PER_BYTE = 16;
   localparam int EDGE_CNT_W = 4;
   localparam int DIV_CNT_W = 8;
   localparam int IDLE_PASS_CYCLES = 2;
endpackage

/* core/sbsf_rate_gen.sv */
// prescaler and power-of-two divider making half-bit ticks for the master serial clock
`timescale 1ns/1ps
module sbsf_rate_gen (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic run_i,
   input wire logic [sbsf_pkg::SEL_W-1:0] pre_sel_i,
   input wire logic [sbsf_pkg::SEL_W-1:0] rate_sel_i,
   output logic half_tick_o
);
   import sbsf_pkg::*;
   logic [SEL_W-1:0] pre_cnt_reg;
   logic [DIV_CNT_W-1:0] div_cnt_reg;
   logic half_tick_reg;
   logic pre_tick;
   logic [DIV_CNT_W-1:0] div_top;
   logic div_wrap;

   // ----------------------------------------
   // prescaler from bus clock, divider on its ticks
   // ----------------------------------------
   assign pre_tick = run_i & (pre_cnt_reg >= pre_sel_i);
   assign div_top = DIV_CNT_W'((9'h001 << rate_sel_i) - 9'h001);
   assign div_wrap = pre_tick & (div_cnt_reg >= div_top);
   assign half_tick_o = half_tick_reg;

   always_ff @(posedge ref_clk) begin
      if (rst || !run_i) begin
         pre_cnt_reg <= '0;
         div_cnt_reg <= '0;
         half_tick_reg <= 1'b0;
      end else begin
         pre_cnt_reg <= pre_tick ? '0 : pre_cnt_reg + 3'h1;
         if (pre_tick) begin
            div_cnt_reg <= div_wrap ? '0 : div_cnt_reg + 8'h01;
         end
         half_tick_reg <= div_wrap;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   logic [11:0] gap_reg;
   logic seen_reg;
   logic [11:0] gap_want;
   logic [2*SEL_W-1:0] sel_q_reg;
   logic sel_same;
   assign gap_want = 12'((12'({9'h000, pre_sel_i}) + 12'h001) << rate_sel_i);
   assign sel_same = {pre_sel_i, rate_sel_i} == sel_q_reg;
   // a rate change mid-run voids the period in flight, so measuring restarts
   always_ff @(posedge ref_clk) begin
      if (rst || !run_i) begin
         gap_reg <= '0;
         seen_reg <= 1'b0;
         sel_q_reg <= {pre_sel_i, rate_sel_i};
      end else begin
         gap_reg <= half_tick_reg ? 12'h001 : gap_reg + 12'h001;
         seen_reg <= (seen_reg | half_tick_reg) & sel_same;
         sel_q_reg <= {pre_sel_i, rate_sel_i};
      end
   end

   half_period_a: assert property (@(posedge ref_clk) disable iff (rst)
      run_i && seen_reg && sel_same && half_tick_reg |-> gap_reg == gap_want)
      else $error("half-bit period differs from selected divisor");
   prescale_tick_a: assert property (@(posedge ref_clk) disable iff (rst)
      run_i && pre_sel_i == 3'h0 && $past(run_i) && $past(pre_sel_i) == 3'h0
      && rate_sel_i == 3'h0 && $past(rate_sel_i) == 3'h0 && $past(run_i, 2)
      |-> half_tick_reg)
      else $error("divide by two not producing a tick every cycle");
endmodule

/* core/sbsf_top.sv */
// serial interface bit-rate generator and status flags behind a wishbone slave
//
// The Wishbone slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module sbsf_top (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [sbsf_pkg::ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [sbsf_pkg::DATA_W-1:0] wb_dat_i,
   output logic [sbsf_pkg::DATA_W-1:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic miso_i,
   input wire logic sel_n_i,
   output logic mosi_o,
   output logic sck_o,
   output logic irq_o
);
   import sbsf_pkg::*;

   typedef enum logic {SBSF_IDLE, SBSF_SHIFT} sbsf_state_t;

   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic ack_reg;
   logic [DATA_W-1:0] rdata_reg;
   logic [BYTE_W-1:0] bit_rate_reg;
   logic [BYTE_W-1:0] ctrl_one_reg;
   logic [BYTE_W-1:0] ctrl_two_reg;
   logic [BYTE_W-1:0] tx_buf_reg;
   logic tx_valid_reg;
   logic [BYTE_W-1:0] rx_buf_reg;
   logic [BYTE_W-1:0] shift_reg;
   logic [EDGE_CNT_W-1:0] edge_reg;
   logic sck_reg;
   logic mosi_reg;
   logic irq_reg;
   sbsf_state_t state_reg;
   sbsf_state_t state_next;

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   logic req;
   logic wr;
   logic rd;
   logic lane0;
   logic hit_rate;
   logic hit_status;
   logic hit_data;
   logic hit_c1;
   logic hit_c2;
   logic [BYTE_W-1:0] wbyte;
   assign req = wb_cyc_i & wb_stb_i & ~ack_reg;
   assign wr = req & wb_we_i;
   assign rd = req & ~wb_we_i;
   assign lane0 = wb_sel_i[0];
   assign wbyte = wb_dat_i[BYTE_W-1:0];
   assign hit_rate = wb_adr_i == OFS_BIT_RATE;
   assign hit_status = wb_adr_i == OFS_STATUS;
   assign hit_data = wb_adr_i == OFS_DATA;
   assign hit_c1 = wb_adr_i == OFS_CTRL_ONE;
   assign hit_c2 = wb_adr_i == OFS_CTRL_TWO;

   // ----------------------------------------
   // control fields
   // ----------------------------------------
   logic enable;
   logic master;
   logic fault_en;
   logic sel_out_en;
   logic tx_irq_en;
   logic rx_irq_en;
   assign enable = ctrl_one_reg[C1_ENABLE];
   assign master = ctrl_one_reg[C1_MASTER];
   assign sel_out_en = ctrl_one_reg[C1_SEL_OUT_EN];
   assign tx_irq_en = ctrl_one_reg[C1_TX_IRQ_EN];
   assign rx_irq_en = ctrl_one_reg[C1_RX_IRQ_EN];
   assign fault_en = ctrl_two_reg[C2_FAULT_EN];

   // ----------------------------------------
   // flags
   // ----------------------------------------
   logic rx_full;
   logic tx_empty;
   logic fault;
   logic tx_armed;
   logic status_rd;
   logic data_rd;
   logic data_wr;
   logic c1_wr;
   logic wr_accept;
   logic load_shift;
   logic shift_done;
   logic fault_set;
   logic [BYTE_W-1:0] status_byte;
   assign status_rd = rd & hit_status;
   assign data_rd = rd & hit_data;
   assign data_wr = wr & hit_data & lane0;
   assign c1_wr = wr & hit_c1 & lane0;
   assign wr_accept = data_wr & tx_armed & enable;
   assign fault_set = enable & master & fault_en & ~sel_out_en & ~sel_n_i;

   sbsf_flag_cell u_rx_full (
      .ref_clk(ref_clk),
      .rst(rst),
      .set_i(shift_done & enable),
      .status_read_i(status_rd),
      .access_i(data_rd),
      .flush_i(~enable),
      .reset_val_i(1'b0),
      .flag_o(rx_full),
      .armed_o()
   );

   sbsf_flag_cell u_tx_empty (
      .ref_clk(ref_clk),
      .rst(rst),
      .set_i(load_shift | ~enable),
      .status_read_i(status_rd),
      .access_i(data_wr),
      .flush_i(1'b0),
      .reset_val_i(1'b1),
      .flag_o(tx_empty),
      .armed_o(tx_armed)
   );

   sbsf_flag_cell u_fault (
      .ref_clk(ref_clk),
      .rst(rst),
      .set_i(fault_set),
      .status_read_i(status_rd),
      .access_i(c1_wr),
      .flush_i(1'b0),
      .reset_val_i(1'b0),
      .flag_o(fault),
      .armed_o()
   );

   always_comb begin
      status_byte = '0;
      status_byte[ST_RX_FULL] = rx_full;
      status_byte[ST_TX_EMPTY] = tx_empty;
      status_byte[ST_FAULT] = fault;
   end

   // ----------------------------------------
   // read mux
   // ----------------------------------------
   logic [BYTE_W-1:0] rbyte;
   assign rbyte = hit_rate ? bit_rate_reg :
                  hit_status ? status_byte :
                  hit_data ? rx_buf_reg :
                  hit_c1 ? ctrl_one_reg :
                  hit_c2 ? ctrl_two_reg : 8'h00;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ack_reg <= 1'b0;
         rdata_reg <= '0;
      end else begin
         ack_reg <= req;
         rdata_reg <= rd ? {24'h000000, rbyte} : 32'h00000000;
      end
   end

   // ----------------------------------------
   // software registers
   // ----------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         bit_rate_reg <= BIT_RATE_RST;
         ctrl_one_reg <= CTRL_ONE_RST;
         ctrl_two_reg <= CTRL_TWO_RST;
      end else begin
         if (wr && hit_rate && lane0) begin
            bit_rate_reg <= wbyte & BIT_RATE_MASK;
         end
         if (c1_wr) begin
            ctrl_one_reg <= wbyte & CTRL_ONE_MASK;
         end
         if (wr && hit_c2 && lane0) begin
            ctrl_two_reg <= wbyte & CTRL_TWO_MASK;
         end
      end
   end

   // ----------------------------------------
   // bit clock
   // ----------------------------------------
   logic half_tick;
   sbsf_rate_gen u_rate (
      .ref_clk(ref_clk),
      .rst(rst),
      .run_i(state_reg == SBSF_SHIFT),
      .pre_sel_i(bit_rate_reg[PRE_LSB+SEL_W-1:PRE_LSB]),
      .rate_sel_i(bit_rate_reg[RATE_LSB+SEL_W-1:RATE_LSB]),
      .half_tick_o(half_tick)
   );

   // ----------------------------------------
   // transmit buffer and shifter
   // ----------------------------------------
   logic last_edge;
   logic lead_edge;
   assign last_edge = half_tick & (edge_reg == 4'(EDGES_PER_BYTE - 1));
   assign lead_edge = half_tick & ~edge_reg[0];
   assign shift_done = (state_reg == SBSF_SHIFT) & last_edge & enable;
   assign load_shift = enable & master & tx_valid_reg
                       & ((state_reg == SBSF_IDLE) | shift_done);

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         SBSF_IDLE: begin
            if (load_shift) begin
               state_next = SBSF_SHIFT;
            end
         end
         SBSF_SHIFT: begin
            if (shift_done && !load_shift) begin
               state_next = SBSF_IDLE;
            end
         end
      endcase
      if (!enable) begin
         state_next = SBSF_IDLE;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_reg <= SBSF_IDLE;
         tx_valid_reg <= 1'b0;
         tx_buf_reg <= '0;
      end else begin
         state_reg <= state_next;
         if (!enable) begin
            tx_valid_reg <= 1'b0;
         end else if (wr_accept) begin
            tx_valid_reg <= 1'b1;
            tx_buf_reg <= wbyte;
         end else if (load_shift) begin
            tx_valid_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         shift_reg <= '0;
         edge_reg <= '0;
         sck_reg <= 1'b0;
         mosi_reg <= 1'b0;
         rx_buf_reg <= '0;
      end else if (load_shift) begin
         shift_reg <= tx_buf_reg;
         mosi_reg <= tx_buf_reg[BYTE_W-1];
         edge_reg <= '0;
         sck_reg <= 1'b0;
         if (shift_done && !rx_full) begin
            rx_buf_reg <= shift_reg;
         end
      end else if (state_reg == SBSF_SHIFT && enable && half_tick) begin
         edge_reg <= edge_reg + 4'h1;
         sck_reg <= ~sck_reg;
         if (lead_edge) begin
            shift_reg <= {shift_reg[BYTE_W-2:0], miso_i};
         end else begin
            mosi_reg <= shift_reg[BYTE_W-1];
         end
         if (shift_done && !rx_full) begin
            rx_buf_reg <= shift_reg;
         end
      end else if (state_reg == SBSF_IDLE || !enable) begin
         sck_reg <= 1'b0;
      end
   end

   // ----------------------------------------
   // interrupt request
   // ----------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= (tx_empty & tx_irq_en) | ((rx_full | fault) & rx_irq_en);
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rdata_reg;
   assign sck_o = sck_reg;
   assign mosi_o = mosi_reg;
   assign irq_o = irq_reg;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   status_zero_bits_a: assert property (
      status_rd |=> wb_ack_o && wb_dat_o[6] == 1'b0 && wb_dat_o[3:0] == 4'h0)
      else $error("unused status bits not zero");
   rx_set_done_a: assert property (
      shift_done |=> rx_full)
      else $error("receive-full not set after transfer");
   rx_clear_seq_a: assert property (
      $fell(rx_full) |-> $past(!enable) || ($past(data_rd) && $past(rx_full)))
      else $error("receive-full cleared without data read");
   write_discard_a: assert property (
      data_wr && !tx_armed && !load_shift |=> tx_valid_reg == $past(tx_valid_reg))
      else $error("unarmed data write was taken");
   idle_pass_a: assert property (
      wr_accept && state_reg == SBSF_IDLE && !tx_valid_reg && master |-> ##[1:2] tx_empty)
      else $error("transmit-empty not back within two cycles");
   fault_gate_a: assert property (
      $rose(fault) |-> $past(master) && $past(fault_en) && !$past(sel_out_en)
      && !$past(sel_n_i))
      else $error("mode fault set in wrong configuration");
   irq_follow_a: assert property (
      tx_empty && tx_irq_en && $stable(tx_empty) |=> irq_o)
      else $error("transmit interrupt missing");
   disable_flags_a: assert property (
      !enable |=> !rx_full && tx_empty && !tx_valid_reg && state_reg == SBSF_IDLE)
      else $error("disable did not reset transfer state");
   fault_irq_a: assert property (
      ##1 fault && rx_irq_en && $stable(fault) |=> irq_o)
      else $error("fault interrupt missing");

   done_cov: cover property (shift_done);
   queued_cov: cover property (shift_done && load_shift);
   fault_cov: cover property ($rose(fault));
   discard_cov: cover property (data_wr && !tx_armed);
endmodule

/* tb/sbsf_slave_model.sv */
// behavioural serial slave, always selected, answering the block's master link
`timescale 1ns/1ps
module sbsf_slave_model (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic resync_i,
   input wire logic sck_i,
   input wire logic mosi_i,
   input wire logic [7:0] tx_byte_i,
   output logic miso_o,
   output logic [7:0] rx_byte_o,
   output logic done_o
);
   logic sck_reg;
   logic fall;
   logic [2:0] fcnt_reg;
   logic [3:0] eff;
   logic [7:0] cur_reg;
   logic [7:0] rx_sh_reg;
   // ----------
   // shifter
   // ----------
   assign fall = sck_reg & ~sck_i;
   assign eff = {1'b0, fcnt_reg} + {3'h0, fall};
   // next bit shows as soon as the clock falls, msb first
   assign miso_o = eff[3] ? tx_byte_i[7] : cur_reg[3'h7 - eff[2:0]];
   always_ff @(posedge ref_clk) begin
      done_o <= 1'b0;
      if (rst | resync_i) begin
         sck_reg <= 1'b0;
         fcnt_reg <= 3'h0;
         cur_reg <= tx_byte_i;
      end else begin
         sck_reg <= sck_i;
         if (sck_i & ~sck_reg) begin
            rx_sh_reg <= {rx_sh_reg[6:0], mosi_i};
         end
         if (fall) begin
            fcnt_reg <= fcnt_reg + 3'h1;
            if (fcnt_reg == 3'h7) begin
               cur_reg <= tx_byte_i;
               rx_byte_o <= rx_sh_reg;
               done_o <= 1'b1;
            end
         end
      end
   end
endmodule

/* tb/sbsf_top_tb_top.sv */
// self-checking bench for the bit-rate and status-flag block
`timescale 1ns/1ps
module sbsf_top_tb_top;
   import sbsf_pkg::*;
   // ----------
   // bench state
   // ----------
   logic ref_clk, rst, cyc, stb, we, miso, sel_n, mosi, sck, irq, ack, resync, m_done;
   logic [3:0] sel;
   logic [7:0] adr, s_byte, m_rx;
   logic [31:0] wdat, rdat, rdv;
   logic [31:0] exp_q[$];
   logic [31:0] msk_q[$];
   logic [7:0] rx_q[$];
   int failures = 0;
   int checks = 0;
   int exp_half = 1;
   int hi_cnt = 0;
   logic f;
   sbsf_top dut_u (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .miso_i(miso), .sel_n_i(sel_n), .mosi_o(mosi), .sck_o(sck), .irq_o(irq));
   sbsf_slave_model mdl_u (.ref_clk(ref_clk), .rst(rst), .resync_i(resync), .sck_i(sck),
      .mosi_i(mosi), .tx_byte_i(s_byte), .miso_o(miso), .rx_byte_o(m_rx), .done_o(m_done));
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   // ----------
   // checks and bus tasks
   // ----------
   task automatic bad(input string m);
      failures++;
      $display("BAD %0t %s", $time, m);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checks++;
      if (got !== exp) bad(m);
   endtask
   task automatic chk_bit(input logic got, input logic exp, input string m);
      checks++;
      if (got !== exp) bad(m);
   endtask
   task automatic results;
      if (failures == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // waits for ack with no limit of its own; the watchdog ends a hang
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge ref_clk);
      end while (ack !== 1'b1);
      rdv = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      wb(1'b1, a, {24'h0, d});
   endtask
   // expectation is queued first, the watcher compares it at the ack edge
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
      exp_q.push_back({24'h0, e});
      msk_q.push_back({24'hFFFFFF, m});
      wb(1'b0, a, 32'h0);
   endtask
   task automatic wait_rx;
      do begin
         exp_q.push_back(32'h0);
         msk_q.push_back(32'h0);
         wb(1'b0, OFS_STATUS, 32'h0);
      end while (rdv[ST_RX_FULL] !== 1'b1);
   endtask
   task automatic set_rate(input logic [7:0] br, input logic [7:0] sb);
      s_byte <= sb;
      resync <= 1'b1;
      wr(OFS_BIT_RATE, br);
      resync <= 1'b0;
      exp_half = (int'(br[6:4]) + 1) << br[2:0];
   endtask
   task automatic xfer(input logic [7:0] br, input logic [7:0] b, input logic [7:0] sb);
      set_rate(br, sb);
      rd(OFS_STATUS, 8'h20, 8'h20);
      wr(OFS_DATA, b);
      rx_q.push_back(b);
      rd(OFS_STATUS, 8'h20, 8'h20);
      rd(OFS_BIT_RATE, br, 8'hFF);
      wait_rx;
      rd(OFS_STATUS, 8'hA0, 8'hFF);
      rd(OFS_DATA, sb, 8'hFF);
      rd(OFS_STATUS, 8'h20, 8'hFF);
   endtask
   // ----------
   // watchers
   // ----------
   always @(posedge ref_clk) begin
      if (ack === 1'b1 && cyc && !we && exp_q.size() > 0) begin
         if (msk_q[0] != 0) chk(rdat & msk_q[0], exp_q[0], "read data");
         void'(exp_q.pop_front());
         void'(msk_q.pop_front());
      end
      if (m_done === 1'b1) begin
         if (rx_q.size() == 0) bad("unexpected frame");
         else chk({24'h0, m_rx}, {24'h0, rx_q.pop_front()}, "serial out byte");
      end
      if (sck === 1'b1) hi_cnt++;
      else if (hi_cnt != 0) begin
         chk(32'(hi_cnt), 32'(exp_half), "half bit time");
         hi_cnt = 0;
      end
   end
   initial begin
      repeat (60000) @(posedge ref_clk);
      bad("watchdog");
      results;
   end
   // ----------
   // tests
   // ----------
   initial begin
      rst = 1'b1;
      {cyc, stb, we, resync} = 4'h0;
      adr = 8'h00;
      sel = 4'h1;
      wdat = 32'h0;
      sel_n = 1'b1;
      s_byte = 8'h00;
      void'($urandom(32'h2428aea1));
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      // no status read yet, so this data write must be dropped
      wr(OFS_CTRL_ONE, 8'h50);
      wr(OFS_DATA, 8'h3C);
      repeat (40) begin
         @(posedge ref_clk);
         chk_bit(sck, 1'b0, "unarmed write moved");
      end
      rd(OFS_BIT_RATE, 8'h00, 8'hFF);
      rd(OFS_STATUS, 8'h20, 8'hFF);
      wr(OFS_STATUS, 8'hFF);
      rd(OFS_STATUS, 8'h20, 8'hFF);
      rd(8'h14, 8'h00, 8'hFF);
      wr(OFS_BIT_RATE, 8'hFF);
      sel <= 4'h0;
      wr(OFS_BIT_RATE, 8'h11);
      sel <= 4'h1;
      rd(OFS_BIT_RATE, 8'h77, 8'hFF);
      wr(OFS_CTRL_ONE, 8'h70);
      @(posedge ref_clk);
      chk_bit(irq, 1'b1, "tx irq");
      wr(OFS_CTRL_ONE, 8'h50);
      @(posedge ref_clk);
      chk_bit(irq, 1'b0, "tx irq masked");
      for (int i = 0; i < 8; i++) xfer({5'h0, i[2:0]}, 8'h81 ^ i[7:0], 8'h5A + i[7:0]);
      for (int i = 0; i < 8; i++) xfer({1'b0, i[2:0], 4'h1}, 8'hC3, ~i[7:0]);
      repeat (4) xfer({1'b0, 3'($urandom), 2'h0, 2'($urandom)}, 8'($urandom), 8'($urandom));
      // one byte shifting, one queued
      set_rate(8'h72, 8'h96);
      rd(OFS_STATUS, 8'h20, 8'h20);
      wr(OFS_DATA, 8'h11);
      rd(OFS_STATUS, 8'h20, 8'h20);
      wr(OFS_DATA, 8'hEE);
      rd(OFS_STATUS, 8'h00, 8'h20);
      rx_q.push_back(8'h11);
      rx_q.push_back(8'hEE);
      repeat (2) begin
         wait_rx;
         rd(OFS_STATUS, 8'hA0, 8'hFF);
         rd(OFS_DATA, 8'h96, 8'hFF);
      end
      // full receive buffer, then abort a frame by disabling
      rd(OFS_STATUS, 8'h20, 8'h20);
      wr(OFS_DATA, 8'h55);
      rx_q.push_back(8'h55);
      wait_rx;
      rd(OFS_STATUS, 8'hA0, 8'hFF);
      wr(OFS_DATA, 8'hAA);
      repeat (100) @(posedge ref_clk);
      while (sck !== 1'b1) @(posedge ref_clk);
      while (sck !== 1'b0) @(posedge ref_clk);
      wr(OFS_CTRL_ONE, 8'h10);
      set_rate(8'h00, 8'h00);
      rd(OFS_STATUS, 8'h20, 8'hFF);
      repeat (40) begin
         @(posedge ref_clk);
         chk_bit(sck, 1'b0, "clock after abort");
      end
      for (int i = 0; i < 8; i++) begin
         wr(OFS_CTRL_ONE, {3'b110, i[0], 2'b00, i[1], 1'b0});
         wr(OFS_CTRL_TWO, {3'h0, i[2], 4'h0});
         sel_n <= 1'b0;
         repeat (4) @(posedge ref_clk);
         sel_n <= 1'b1;
         f = i[0] & i[2] & ~i[1];
         rd(OFS_STATUS, {3'h1, f, 4'h0}, 8'h30);
         chk_bit(irq, f, "fault irq");
         wr(OFS_CTRL_ONE, 8'h40);
         rd(OFS_STATUS, 8'h20, 8'h30);
      end
      results;
   end
endmodule
